// [src/periodic_timer_pkg.sv]
// Overview of operation
// - Run bit rising clears the counter to zero and starts counting.
// - Run bit falling stops counting; the counter keeps its value.
// - Run bit rising returns the pin to its initial level in compare mode.
// - Mode field bits 7:6 select compare, capture, PWM/pulse or timer.
// - Compare mode match A: no change, drive low, drive high or toggle.
// - PWM mode pin field: inactive, active, PWM waveform or single pulse.
// - Capture mode pin field: rising, falling, both edges or disabled.
// - Match A leaves the pin alone when requested level equals present.
// - Output level bit sets initial level or active level of the pin.
// - Invert bit flips the pin signal in every mode; the pin is driven only in compare and PWM modes.
// - Capture source bit picks the timer pin or the external clock pin.
// - Clear select 1 clears on match A; 0 on match P or overflow.
// - Overflow clearing happens only when the period value is zero.
// - Clear select is ignored in PWM, single pulse and capture modes.
// - Counter readable as low byte and bits 1:0 of the high byte.
// - Compare A value held in a writable low byte and high bits 1:0.
// - Period value held in a writable low byte and high bits; resets zero.
// - Unimplemented control and high-byte bits read as zero.
// - Clock select picks system, divided, subclock or external pin edges.
// - Pause bit freezes the counter; clearing it resumes counting.
// - Match A: nonzero compare A equality (a capture in capture mode); match P: period equality, except in single pulse and clear-on-A modes.
package periodic_timer_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W  = 10;
  localparam int BYTE_W = 8;
  localparam int HI_W   = CNT_W - BYTE_W;
  localparam int HI_PAD = BYTE_W - HI_W;
  localparam int ADDR_W = 3;
  localparam int PRE_W  = 6;

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] A_RUN_CTL  = 3'h0;
  localparam logic [ADDR_W-1:0] A_MODE_CTL = 3'h1;
  localparam logic [ADDR_W-1:0] A_CNT_LO   = 3'h2;
  localparam logic [ADDR_W-1:0] A_CNT_HI   = 3'h3;
  localparam logic [ADDR_W-1:0] A_CMPA_LO  = 3'h4;
  localparam logic [ADDR_W-1:0] A_CMPA_HI  = 3'h5;
  localparam logic [ADDR_W-1:0] A_PER_LO   = 3'h6;
  localparam logic [ADDR_W-1:0] A_PER_HI   = 3'h7;
  localparam int                RUN_LSB    = 3;
  localparam int                RUN_PAD    = 3;

  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } op_mode_t;

  localparam logic [1:0] FN_NONE   = 2'h0;
  localparam logic [1:0] FN_LOW    = 2'h1;
  localparam logic [1:0] FN_HIGH   = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;
  localparam logic [1:0] FN_INACT  = 2'h0;
  localparam logic [1:0] FN_ACT    = 2'h1;
  localparam logic [1:0] FN_PWM    = 2'h2;
  localparam logic [1:0] FN_PULSE  = 2'h3;
  localparam logic [1:0] FN_RISE   = 2'h0;
  localparam logic [1:0] FN_FALL   = 2'h1;
  localparam logic [1:0] FN_BOTH   = 2'h2;

  localparam logic [2:0] CK_SYS4  = 3'h0;
  localparam logic [2:0] CK_SYS   = 3'h1;
  localparam logic [2:0] CK_H16   = 3'h2;
  localparam logic [2:0] CK_H64   = 3'h3;
  localparam logic [2:0] CK_SUB0  = 3'h4;
  localparam logic [2:0] CK_SUB1  = 3'h5;
  localparam logic [2:0] CK_EXT_R = 3'h6;
  localparam logic [2:0] CK_EXT_F = 3'h7;

  localparam logic [PRE_W-1:0] PRE_M4  = 6'h03;
  localparam logic [PRE_W-1:0] PRE_M16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_M64 = 6'h3f;
  localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       run;
  } run_ctl_t;

  typedef struct packed {
    op_mode_t   mode;
    logic [1:0] pin_fn;
    logic       init_level;
    logic       invert;
    logic       cap_src;
    logic       clr_sel;
  } mode_ctl_t;

  typedef struct packed {
    run_ctl_t          run_ctl;
    mode_ctl_t         mode_ctl;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cmpa;
    logic [CNT_W-1:0]  period;
    logic [PRE_W-1:0]  presc;
    logic              run_prev;
    logic              level;
    logic              pin;
    logic              oe;
    logic              flag_a;
    logic              flag_p;
    logic [BYTE_W-1:0] rdata;
    logic              io_s1;
    logic              io_s2;
    logic              io_s3;
    logic              ck_s1;
    logic              ck_s2;
    logic              ck_s3;
  } tmr_state_t;

endpackage

// [src/periodic_timer_10bit.sv]
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_10bit (
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RST_N,
  // Register port
  input  wire periodic_timer_pkg::reg_req_t   REG_REQ,
  output logic [periodic_timer_pkg::BYTE_W-1:0] REG_RDATA,
  // Clock sources
  input  wire logic                           SUB_TICK,
  input  wire logic                           EXT_CLK_IN,
  // Timer pin
  input  wire logic                           TIMER_IO_IN,
  output logic                                TIMER_IO_OUT,
  output logic                                TIMER_IO_OE,
  // Match events
  output logic                                CMP_A_MATCH,
  output logic                                CMP_P_MATCH
);

  // ==========================================================
  // State
  periodic_timer_pkg::tmr_state_t            st_q;
  periodic_timer_pkg::tmr_state_t            st_d;
  logic                                      tick;
  logic                                      rise;
  logic                                      advance;
  logic [periodic_timer_pkg::CNT_W-1:0]      cnt_inc;
  logic                                      match_a;
  logic                                      match_p;
  logic                                      cmp_like;
  logic                                      pulse_mode;
  logic                                      clr_a;
  logic                                      clr_p;
  logic                                      src_now;
  logic                                      src_prev;
  logic                                      cap_ev;
  logic                                      ext_rise;
  logic                                      ext_fall;
  logic                                      pwm_on;

  // ==========================================================
  // Counter clock selection
  assign ext_rise = st_q.ck_s2 & ~st_q.ck_s3;
  assign ext_fall = ~st_q.ck_s2 & st_q.ck_s3;

  always_comb begin
    case (st_q.run_ctl.clk_sel)
      periodic_timer_pkg::CK_SYS4: begin
        tick = (st_q.presc & periodic_timer_pkg::PRE_M4)
               == periodic_timer_pkg::PRE_M4;
      end
      periodic_timer_pkg::CK_SYS: begin
        tick = 1'b1;
      end
      periodic_timer_pkg::CK_H16: begin
        tick = (st_q.presc & periodic_timer_pkg::PRE_M16)
               == periodic_timer_pkg::PRE_M16;
      end
      periodic_timer_pkg::CK_H64: begin
        tick = st_q.presc == periodic_timer_pkg::PRE_M64;
      end
      periodic_timer_pkg::CK_SUB0,
      periodic_timer_pkg::CK_SUB1: begin
        tick = SUB_TICK;
      end
      periodic_timer_pkg::CK_EXT_R: begin
        tick = ext_rise;
      end
      periodic_timer_pkg::CK_EXT_F: begin
        tick = ext_fall;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Counter events
  assign rise       = st_q.run_ctl.run & ~st_q.run_prev;
  assign advance    = st_q.run_ctl.run & st_q.run_prev
                      & ~st_q.run_ctl.pause & tick;
  assign cnt_inc    = st_q.cnt + periodic_timer_pkg::CNT_ONE;
  assign match_a    = advance & (cnt_inc == st_q.cmpa);
  assign match_p    = advance & (cnt_inc == st_q.period);
  assign cmp_like   = (st_q.mode_ctl.mode == periodic_timer_pkg::MODE_COMPARE)
                      | (st_q.mode_ctl.mode == periodic_timer_pkg::MODE_TIMER);
  assign pulse_mode = (st_q.mode_ctl.mode == periodic_timer_pkg::MODE_PWM)
                      & (st_q.mode_ctl.pin_fn == periodic_timer_pkg::FN_PULSE);
  assign clr_a      = cmp_like & st_q.mode_ctl.clr_sel & match_a;
  assign clr_p      = match_p & ~pulse_mode
                      & ~(cmp_like & st_q.mode_ctl.clr_sel);
  assign pwm_on     = st_q.cnt < st_q.cmpa;

  // ==========================================================
  // Capture trigger
  assign src_now  = st_q.mode_ctl.cap_src ? st_q.ck_s2 : st_q.io_s2;
  assign src_prev = st_q.mode_ctl.cap_src ? st_q.ck_s3 : st_q.io_s3;

  always_comb begin
    case (st_q.mode_ctl.pin_fn)
      periodic_timer_pkg::FN_RISE: begin
        cap_ev = src_now & ~src_prev;
      end
      periodic_timer_pkg::FN_FALL: begin
        cap_ev = ~src_now & src_prev;
      end
      periodic_timer_pkg::FN_BOTH: begin
        cap_ev = src_now ^ src_prev;
      end
      default: begin
        cap_ev = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d          = st_q;
    st_d.io_s1    = TIMER_IO_IN;
    st_d.io_s2    = st_q.io_s1;
    st_d.io_s3    = st_q.io_s2;
    st_d.ck_s1    = EXT_CLK_IN;
    st_d.ck_s2    = st_q.ck_s1;
    st_d.ck_s3    = st_q.ck_s2;
    st_d.presc    = st_q.presc + periodic_timer_pkg::PRE_ONE;
    st_d.run_prev = st_q.run_ctl.run;
    st_d.flag_a   = 1'b0;
    st_d.flag_p   = 1'b0;
    st_d.rdata    = '0;

    // Register writes
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        periodic_timer_pkg::A_RUN_CTL: begin
          st_d.run_ctl = REG_REQ.wdata[periodic_timer_pkg::BYTE_W-1:
                                       periodic_timer_pkg::RUN_LSB];
        end
        periodic_timer_pkg::A_MODE_CTL: begin
          st_d.mode_ctl =
            periodic_timer_pkg::mode_ctl_t'(REG_REQ.wdata);
        end
        periodic_timer_pkg::A_CMPA_LO: begin
          st_d.cmpa[periodic_timer_pkg::BYTE_W-1:0] = REG_REQ.wdata;
        end
        periodic_timer_pkg::A_CMPA_HI: begin
          st_d.cmpa[periodic_timer_pkg::CNT_W-1:periodic_timer_pkg::BYTE_W] =
            REG_REQ.wdata[periodic_timer_pkg::HI_W-1:0];
        end
        periodic_timer_pkg::A_PER_LO: begin
          st_d.period[periodic_timer_pkg::BYTE_W-1:0] = REG_REQ.wdata;
        end
        periodic_timer_pkg::A_PER_HI: begin
          st_d.period[periodic_timer_pkg::CNT_W-1:periodic_timer_pkg::BYTE_W] =
            REG_REQ.wdata[periodic_timer_pkg::HI_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        periodic_timer_pkg::A_RUN_CTL: begin
          st_d.rdata = {st_q.run_ctl, {periodic_timer_pkg::RUN_PAD{1'b0}}};
        end
        periodic_timer_pkg::A_MODE_CTL: begin
          st_d.rdata = st_q.mode_ctl;
        end
        periodic_timer_pkg::A_CNT_LO: begin
          st_d.rdata = st_q.cnt[periodic_timer_pkg::BYTE_W-1:0];
        end
        periodic_timer_pkg::A_CNT_HI: begin
          st_d.rdata = {{periodic_timer_pkg::HI_PAD{1'b0}},
            st_q.cnt[periodic_timer_pkg::CNT_W-1:periodic_timer_pkg::BYTE_W]};
        end
        periodic_timer_pkg::A_CMPA_LO: begin
          st_d.rdata = st_q.cmpa[periodic_timer_pkg::BYTE_W-1:0];
        end
        periodic_timer_pkg::A_CMPA_HI: begin
          st_d.rdata = {{periodic_timer_pkg::HI_PAD{1'b0}},
            st_q.cmpa[periodic_timer_pkg::CNT_W-1:periodic_timer_pkg::BYTE_W]};
        end
        periodic_timer_pkg::A_PER_LO: begin
          st_d.rdata = st_q.period[periodic_timer_pkg::BYTE_W-1:0];
        end
        periodic_timer_pkg::A_PER_HI: begin
          st_d.rdata = {{periodic_timer_pkg::HI_PAD{1'b0}},
            st_q.period[periodic_timer_pkg::CNT_W-1:
                        periodic_timer_pkg::BYTE_W]};
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end

    // Counter
    if (rise) begin
      st_d.cnt = '0;
    end else if (advance) begin
      st_d.cnt = cnt_inc;
      if (clr_a || clr_p) begin
        st_d.cnt = '0;
      end
    end

    // Match events and capture
    st_d.flag_p = clr_p | (match_p & ~pulse_mode & ~clr_a
                  & ~(cmp_like & st_q.mode_ctl.clr_sel));
    if (st_q.mode_ctl.mode == periodic_timer_pkg::MODE_CAPTURE) begin
      if (cap_ev && st_q.run_ctl.run) begin
        st_d.cmpa   = st_q.cnt;
        st_d.flag_a = 1'b1;
      end
    end else begin
      st_d.flag_a = match_a & (st_q.cmpa != '0);
    end

    // Single pulse run control: match A clears run; external pin rising edge sets it only while run is clear
    if (pulse_mode && match_a) begin
      st_d.run_ctl.run = 1'b0;
    end
    if (pulse_mode && ext_rise && !st_q.run_ctl.run) begin
      st_d.run_ctl.run = 1'b1;
    end

    // Output level
    case (st_q.mode_ctl.mode)
      periodic_timer_pkg::MODE_COMPARE: begin
        if (rise) begin
          st_d.level = st_q.mode_ctl.init_level;
        end else if (match_a && st_q.cmpa != '0) begin
          case (st_q.mode_ctl.pin_fn)
            periodic_timer_pkg::FN_LOW: begin
              st_d.level = 1'b0;
            end
            periodic_timer_pkg::FN_HIGH: begin
              st_d.level = 1'b1;
            end
            periodic_timer_pkg::FN_TOGGLE: begin
              st_d.level = ~st_q.level;
            end
            default: begin
              st_d.level = st_q.level;
            end
          endcase
        end
      end
      periodic_timer_pkg::MODE_PWM: begin
        case (st_q.mode_ctl.pin_fn)
          periodic_timer_pkg::FN_INACT: begin
            st_d.level = ~st_q.mode_ctl.init_level;
          end
          periodic_timer_pkg::FN_ACT: begin
            st_d.level = st_q.mode_ctl.init_level;
          end
          periodic_timer_pkg::FN_PWM: begin
            st_d.level = (st_q.run_ctl.run && pwm_on)
                         ? st_q.mode_ctl.init_level
                         : ~st_q.mode_ctl.init_level;
          end
          default: begin
            st_d.level = st_d.run_ctl.run
                         ? st_q.mode_ctl.init_level
                         : ~st_q.mode_ctl.init_level;
          end
        endcase
      end
      default: begin
        st_d.level = st_q.level;
      end
    endcase

    // Pin drive
    st_d.pin = st_d.level ^ st_d.mode_ctl.invert;
    st_d.oe  = (st_d.mode_ctl.mode == periodic_timer_pkg::MODE_COMPARE)
               | (st_d.mode_ctl.mode == periodic_timer_pkg::MODE_PWM);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA    = st_q.rdata;
  assign TIMER_IO_OUT = st_q.pin;
  assign TIMER_IO_OE  = st_q.oe;
  assign CMP_A_MATCH  = st_q.flag_a;
  assign CMP_P_MATCH  = st_q.flag_p;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_run_rise_clear: assert property (rise |=> st_q.cnt == '0)
    else $error("counter not cleared on run start");

  a_stop_holds: assert property (
    !st_q.run_ctl.run ##1 !st_q.run_ctl.run |-> $stable(st_q.cnt))
    else $error("counter moved while stopped");

  a_pause_holds: assert property (
    st_q.run_ctl.pause && !rise |=> $stable(st_q.cnt))
    else $error("counter moved while paused");

  a_init_level: assert property (
    rise && st_q.mode_ctl.mode == periodic_timer_pkg::MODE_COMPARE
    |=> st_q.level == $past(st_q.mode_ctl.init_level))
    else $error("pin not returned to initial level");

  a_match_toggle: assert property (
    match_a && !rise && st_q.cmpa != '0
    && st_q.mode_ctl.mode == periodic_timer_pkg::MODE_COMPARE
    && st_q.mode_ctl.pin_fn == periodic_timer_pkg::FN_TOGGLE
    |=> st_q.level != $past(st_q.level) && CMP_A_MATCH)
    else $error("toggle on match A missing");

  a_clear_on_a: assert property (
    clr_a |=> st_q.cnt == '0 && CMP_A_MATCH == ($past(st_q.cmpa) != '0))
    else $error("match A did not clear the counter");

  a_no_p_flag: assert property (
    cmp_like && st_q.mode_ctl.clr_sel |=> !CMP_P_MATCH)
    else $error("period flag raised with clear on match A");

  a_overflow_clear: assert property (
    advance && !rise && cmp_like && !st_q.mode_ctl.clr_sel
    && st_q.period == '0 && st_q.cnt == periodic_timer_pkg::CNT_MAX
    |=> st_q.cnt == '0 && CMP_P_MATCH)
    else $error("overflow did not clear the counter");

  a_pwm_no_clr_a: assert property (
    st_q.mode_ctl.mode == periodic_timer_pkg::MODE_PWM && match_a
    && !match_p && !rise && cnt_inc != '0
    |=> st_q.cnt != '0)
    else $error("clear select acted in PWM mode");

  a_pin_invert: assert property (
    TIMER_IO_OUT == (st_q.level ^ st_q.mode_ctl.invert))
    else $error("pin polarity wrong");

  a_cnt_read: assert property (
    REG_REQ.rd && REG_REQ.addr == periodic_timer_pkg::A_CNT_LO
    |=> REG_RDATA == $past(st_q.cnt[periodic_timer_pkg::BYTE_W-1:0]))
    else $error("counter low byte read wrong");

  a_hi_reserved: assert property (
    REG_REQ.rd && REG_REQ.addr[0]
    && REG_REQ.addr != periodic_timer_pkg::A_MODE_CTL
    |=> REG_RDATA[periodic_timer_pkg::BYTE_W-1:periodic_timer_pkg::HI_W]
        == '0)
    else $error("reserved bits not zero");

  a_capture: assert property (
    st_q.mode_ctl.mode == periodic_timer_pkg::MODE_CAPTURE && cap_ev
    && st_q.run_ctl.run |=> st_q.cmpa == $past(st_q.cnt) && CMP_A_MATCH)
    else $error("capture did not load compare A");

  c_pwm_period: cover property (
    st_q.mode_ctl.mode == periodic_timer_pkg::MODE_PWM && clr_p);
  c_pulse_end: cover property (pulse_mode && match_a);
  c_capture: cover property (
    st_q.mode_ctl.mode == periodic_timer_pkg::MODE_CAPTURE && cap_ev);
  c_overflow: cover property (advance && cnt_inc == '0);

endmodule
`default_nettype wire

// [test/timer_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_pins (
  // Design side of the timer pin
  input  wire logic oe,
  input  wire logic out,
  // Far side levels
  input  wire logic io_drv,
  input  wire logic ext_drv,
  // Wire levels
  output logic      pad,
  output logic      ext_pin
);
  // ====================
  // Pin wire levels
  assign pad     = oe ? out : io_drv;
  assign ext_pin = ext_drv;
endmodule
`default_nettype wire

// [test/periodic_timer_10bit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_10bit_tb;
  // ====================
  // Signals
  logic                         clk      = 1'b0;
  logic                         rst_n    = 1'b0;
  periodic_timer_pkg::reg_req_t req      = '0;
  logic [7:0]                   rdata;
  logic                         io_drv   = 1'b0;
  logic                         ext_drv  = 1'b0;
  logic                         sub_tick = 1'b0;
  logic                         pad;
  logic                         ext_pin;
  logic                         io_out;
  logic                         io_oe;
  logic                         ma;
  logic                         mp;
  int                           n_errors = 0;
  int                           checked  = 0;
  int                           na       = 0;
  int                           np       = 0;
  int                           a0;
  int                           p0;
  logic [31:0]                  e;
  logic [7:0]                   v;
  logic [7:0]                   v1;
  // Mode, start, two samples, A count, P count, enable
  localparam logic [31:0] PIN_TAB [11] = '{
    32'h20011431, 32'h10000431, 32'h18100431, 32'h30010431,
    32'h24100431, 32'h08111431, 32'h21011701, 32'ha9111431,
    32'h88000431, 32'h98111431, 32'he8000430};
  localparam logic [23:0] RB_TAB [8] = '{
    24'h01ffff, 24'h00f7f0, 24'h05ff03, 24'h07ff03,
    24'h04a5a5, 24'h065a5a, 24'h02ff00, 24'h03ff00};
  localparam logic [15:0] CAP_TAB [6] = '{
    16'h4001, 16'h5001, 16'h6002, 16'h7000, 16'h4201, 16'h6202};
  // Run byte, cycles between reads, expected ticks
  localparam logic [23:0] CK_TAB [3] = '{
    24'h080e04, 24'h283e04, 24'h387e02};

  // ====================
  // Clock, design and pins
  always #2.5 clk = ~clk;

  periodic_timer_10bit u_periodic_timer_10bit (
    .CLK          (clk),
    .RST_N        (rst_n),
    .REG_REQ      (req),
    .REG_RDATA    (rdata),
    .SUB_TICK     (sub_tick),
    .EXT_CLK_IN   (ext_pin),
    .TIMER_IO_IN  (pad),
    .TIMER_IO_OUT (io_out),
    .TIMER_IO_OE  (io_oe),
    .CMP_A_MATCH  (ma),
    .CMP_P_MATCH  (mp)
  );

  timer_pins u_timer_pins (
    .oe      (io_oe),
    .out     (io_out),
    .io_drv  (io_drv),
    .ext_drv (ext_drv),
    .pad     (pad),
    .ext_pin (ext_pin)
  );

  always @(posedge clk) begin
    if (ma === 1'b1) na <= na + 1;
    if (mp === 1'b1) np <= np + 1;
  end

  // ====================
  // Tasks
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), v);
      check("reset value", v, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      wr(RB_TAB[i][18:16], RB_TAB[i][15:8]);
      rd(RB_TAB[i][18:16], v);
      check("readback", v, RB_TAB[i][7:0]);
    end
    wr(3'h0, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h7, 8'h00);
    wr(3'h4, 8'h04);
    wr(3'h6, 8'h08);
    for (int i = 0; i < 11; i++) begin
      e = PIN_TAB[i];
      wr(3'h0, 8'h00);
      wr(3'h1, e[31:24]);
      wr(3'h0, 8'h18);
      a0 = na;
      p0 = np;
      repeat (3) @(posedge clk);
      #1 check("pin start", 8'(pad), 8'(e[23:20]));
      check("pin enable", 8'(io_oe), 8'(e[3:0]));
      repeat (7) @(posedge clk);
      #1 check("pin first", 8'(pad), 8'(e[19:16]));
      repeat (8) @(posedge clk);
      #1 check("pin second", 8'(pad), 8'(e[15:12]));
      repeat (14) @(posedge clk);
      #1 check("a count", 8'(na - a0), 8'(e[11:8]));
      check("p count", 8'(np - p0), 8'(e[7:4]));
    end
    wr(3'h0, 8'h98);
    rd(3'h2, v1);
    repeat (5) @(posedge clk);
    rd(3'h2, v);
    check("paused count", v, v1);
    wr(3'h0, 8'h18);
    rd(3'h2, v);
    check("resumed", 8'(v != v1), 8'h01);
    wr(3'h0, 8'h10);
    rd(3'h2, v1);
    repeat (5) @(posedge clk);
    rd(3'h2, v);
    check("stopped count", v, v1);
    wr(3'h0, 8'h18);
    rd(3'h2, v);
    check("restart count", v, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h6, 8'h00);
    wr(3'h0, 8'h18);
    a0 = na;
    p0 = np;
    repeat (2080) @(posedge clk);
    #1 check("overflow p", 8'(np - p0), 8'h02);
    check("overflow a", 8'(na - a0), 8'h00);
    wr(3'h6, 8'h08);
    for (int i = 0; i < 6; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, CAP_TAB[i][15:8]);
      wr(3'h0, 8'h18);
      a0 = na;
      repeat (4) @(posedge clk);
      io_drv <= 1'b1;
      repeat (8) @(posedge clk);
      io_drv <= 1'b0;
      repeat (8) @(posedge clk);
      ext_drv <= 1'b1;
      repeat (8) @(posedge clk);
      ext_drv <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check("captures", 8'(na - a0), CAP_TAB[i][7:0]);
    end
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h06);
    wr(3'h1, 8'hb8);
    ext_drv <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check("pulse lead", 8'(pad), 8'h01);
    repeat (60) @(posedge clk);
    #1 check("pulse trail", 8'(pad), 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hc0);
    wr(3'h6, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h0, CK_TAB[i][23:16]);
      rd(3'h2, v1);
      repeat (CK_TAB[i][15:8]) @(posedge clk);
      rd(3'h2, v);
      check("prescaled ticks", v - v1, CK_TAB[i][7:0]);
    end
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h48);
    repeat (5) begin
      @(posedge clk);
      sub_tick <= 1'b1;
      @(posedge clk);
      sub_tick <= 1'b0;
    end
    rd(3'h2, v);
    check("sub ticks", v, 8'h05);
    for (int i = 0; i < 2; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h0, (i == 0) ? 8'h68 : 8'h78);
      repeat (3) begin
        repeat (4) @(posedge clk);
        ext_drv <= 1'b0;
        repeat (4) @(posedge clk);
        ext_drv <= 1'b1;
      end
      repeat (4) @(posedge clk);
      rd(3'h2, v);
      check("pin ticks", v, 8'h03);
    end
    print_verdict();
  end

  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
